// ===== dv/lbds_assertions.sv
// Checker on the sequencer register port and drive outputs
`timescale 1ns/1ps
module lbds_chk
  import lbds_pkg::*;
(
  // Clock and reset
  input wire logic             clk_sys,
  input wire logic             rst_n,
  // Register port
  input wire logic [7:0]       regAddr,
  input wire logic [7:0]       regWrData,
  input wire logic             regWrEn,
  input wire logic             regRdEn,
  input wire logic [7:0]       regRdData,
  // Drive settings
  input wire logic [CUR_W-1:0] aSinkCurrentCode,
  input wire logic             aRampSel,
  input wire logic [CUR_W-1:0] bSinkCurrentCode,
  input wire logic             bRampSel,
  input wire logic [LEN_W-1:0] bPhase1Len
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Read data is quiet unless a read was taken
  AST_RD_IDLE:
    assert property (!regRdEn |=> regRdData == 8'h00) else $error("stray read data");
  AST_RD_UNMAP:
    assert property (regRdEn && (regAddr < 8'h47 || regAddr > 8'h50) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  AST_RD_LEN:
    assert property (regRdEn && regAddr inside {[8'h48:8'h4C], 8'h50} |=> !regRdData[7])
    else $error("length register top bit set");
  AST_RD_NARROW:
    assert property (regRdEn && regAddr inside {8'h4D, 8'h4E} |=> regRdData[7:5] == 3'h0)
    else $error("duty or lit time upper bits set");
  AST_RD_CUR:
    assert property (regRdEn && regAddr == ADDR_B_CURRENT |=>
      regRdData == {2'h0, bRampSel, 1'b0, bSinkCurrentCode}) else $error("B current readback");
  // Outputs follow the write that hit them
  AST_A_CUR_WR:
    assert property (regWrEn && regAddr == ADDR_A_CURRENT |=>
      {aRampSel, aSinkCurrentCode} == {$past(regWrData[5]), $past(regWrData[3:0])})
    else $error("A current not taken");
  AST_B_CUR_WR:
    assert property (regWrEn && regAddr == ADDR_B_CURRENT |=>
      {bRampSel, bSinkCurrentCode} == {$past(regWrData[5]), $past(regWrData[3:0])})
    else $error("B current not taken");
  AST_B_PH1_WR:
    assert property (regWrEn && regAddr == ADDR_B_PH1 |=> bPhase1Len == $past(regWrData[6:0]))
    else $error("B phase one length not taken");
  AST_B_PH1_HOLD:
    assert property (!(regWrEn && regAddr == ADDR_B_PH1) |=> $stable(bPhase1Len))
    else $error("B phase one length moved");
endmodule // lbds_chk

bind lbds_top lbds_chk chk_u (.clk_sys, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn,
  .regRdData, .aSinkCurrentCode, .aRampSel, .bSinkCurrentCode, .bRampSel, .bPhase1Len);

// ===== dv/lbds_bench.sv
// Self-checking bench for the LED blink and dimming sequencer
`timescale 1ns/1ps
`define CHK(n, e, s) begin checkCount++; if ((s) !== (e)) begin errors++; \
  $display("Error %s expected %0h seen %0h", n, e, s); end end
module lbds_bench
  import lbds_pkg::*;
;
  logic             clk_sys, rst_n, regWrEn, regRdEn, aLightSignal, aRampSel, bRampSel;
  logic [7:0]       regAddr, regWrData, regRdData, rdVal;
  logic [CUR_W-1:0] aSinkCurrentCode, bSinkCurrentCode;
  logic [LEN_W-1:0] bPhase1Len;
  int               errors, checkCount, cycles, hi, runLen, lastLen;
  logic [7:0]       addrTab [10] = '{8'h47, 8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h4D, 8'h4E,
                                     8'h4F, 8'h50};
  logic [7:0]       maskTab [10] = '{8'h2F, 8'h7F, 8'h7F, 8'h7F, 8'h7F, 8'h7F, 8'h1F, 8'h1F,
                                     8'h2F, 8'h7F};

  lbds_top dut_u (.clk_sys, .rst_n, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
    .aLightSignal, .aSinkCurrentCode, .aRampSel, .bSinkCurrentCode, .bRampSel, .bPhase1Len);
  lbds_led_model led_u (.clk_sys, .aLightSignal, .runLen, .lastLen);

  // 40 MHz clock; ceiling sized for about 75k cycles of tests
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 95000) begin
      errors++;
      complete_run();
    end
  end

  task automatic do_reset();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clk_sys);
    regWrEn <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    @(negedge clk_sys);
    d = regRdData;
  endtask

  task automatic check_zero();
    for (int i = 0; i < 10; i++) begin
      rd(addrTab[i], rdVal);
      `CHK("reset value", 8'h00, rdVal)
    end
  endtask

  // Bounded wait for the light to reach a level
  task automatic wait_light(input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (aLightSignal !== v && n < lim);
    `CHK("light level", v, aLightSignal)
  endtask

  task automatic test_regs();
    check_zero();
    for (int i = 0; i < 10; i++) wr(addrTab[i], 8'hFF);
    wr(8'h46, 8'hFF);
    wr(8'h51, 8'hFF);
    for (int i = 0; i < 10; i++) begin
      rd(addrTab[i], rdVal);
      `CHK("masked readback", maskTab[i], rdVal)
    end
    rd(8'h46, rdVal);
    `CHK("unmapped low", 8'h00, rdVal)
    rd(8'h51, rdVal);
    `CHK("unmapped high", 8'h00, rdVal)
    `CHK("A drive", 5'h1F, {aRampSel, aSinkCurrentCode})
    `CHK("B drive", 5'h1F, {bRampSel, bSinkCurrentCode})
    `CHK("B phase one", 7'h7F, bPhase1Len)
    do_reset();
    check_zero();
    `CHK("drive after reset", 17'h0, {aRampSel, aSinkCurrentCode, bRampSel,
      bSinkCurrentCode, bPhase1Len})
    $display("register test done");
  endtask

  // One lit phase of one unit; measure the first high slot run
  task automatic test_pwm(input logic [7:0] duty, input int expLen);
    do_reset();
    wr(8'h4D, duty);
    wr(8'h4E, 8'h01);
    wr(8'h48, 8'h01);
    wait_light(1'b1, 50);
    wait_light(1'b0, expLen + 50);
    @(negedge clk_sys);
    `CHK("lit run", expLen, lastLen)
    $display("pwm test duty %0d done", duty);
  endtask

  // Zero lit time keeps it dark; full duty never drops
  task automatic test_full();
    do_reset();
    wr(8'h4D, 8'h1F);
    wr(8'h48, 8'h01);
    hi = 0;
    repeat (2000) @(negedge clk_sys) if (aLightSignal !== 1'b0) hi++;
    `CHK("dark with zero lit time", 0, hi)
    wr(8'h4E, 8'h01);
    wait_light(1'b1, 50);
    repeat (40000) @(negedge clk_sys);
    `CHK("full duty run", 40000, runLen)
    $display("full duty test done");
  endtask

  // Zero-length phases are skipped and phase three is lit
  task automatic test_skip();
    do_reset();
    wr(8'h4D, 8'h1F);
    wr(8'h4E, 8'h01);
    wr(8'h4A, 8'h01);
    wait_light(1'b1, 50);
    repeat (100) @(negedge clk_sys);
    `CHK("phase three lit", 1'b1, aLightSignal)
    $display("skip test done");
  endtask

  task automatic complete_run();
    $display("Checks %0d errors %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    do_reset();
    test_regs();
    test_pwm(8'h00, 10000);
    test_pwm(8'h01, 20000);
    test_full();
    test_skip();
    complete_run();
  end
endmodule // lbds_bench

// ===== dv/lbds_led_model.sv
// Behavioural LED on the light output, measuring lit runs
`timescale 1ns/1ps
module lbds_led_model (
  // Clock and drive
  input wire logic clk_sys,
  input wire logic aLightSignal,
  // Measured glow
  output int       runLen,
  output int       lastLen
);
  // Count clocks of each lit run and keep the last finished one
  always @(posedge clk_sys) begin
    if (aLightSignal === 1'b1) begin
      runLen <= runLen + 1;
    end else begin
      if (runLen != 0) lastLen <= runLen;
      runLen <= 0;
    end
  end
endmodule // lbds_led_model

// ===== verilog/lbds_pkg.sv
// Constants shared by the LED blink and dimming sequencer
package lbds_pkg;

  // Register offsets on the byte register port
  localparam logic [7:0] ADDR_A_CURRENT = 8'h47;
  localparam logic [7:0] ADDR_A_PH1     = 8'h48;
  localparam logic [7:0] ADDR_A_PH2     = 8'h49;
  localparam logic [7:0] ADDR_A_PH3     = 8'h4A;
  localparam logic [7:0] ADDR_A_PH4     = 8'h4B;
  localparam logic [7:0] ADDR_A_PAUSE   = 8'h4C;
  localparam logic [7:0] ADDR_A_DUTY    = 8'h4D;
  localparam logic [7:0] ADDR_A_ONTIME  = 8'h4E;
  localparam logic [7:0] ADDR_B_CURRENT = 8'h4F;
  localparam logic [7:0] ADDR_B_PH1     = 8'h50;

  // Field layout
  localparam int CUR_W    = 4;
  localparam int RAMP_BIT = 5;
  localparam int LEN_W    = 7;
  localparam int DUTY_W   = 5;
  localparam int ONT_W    = 5;

  // Values after power-on reset
  localparam logic [CUR_W-1:0]  RST_CUR  = 4'h0;
  localparam logic              RST_RAMP = 1'b0;
  localparam logic [LEN_W-1:0]  RST_LEN  = 7'h00;
  localparam logic [DUTY_W-1:0] RST_DUTY = 5'h00;
  localparam logic [ONT_W-1:0]  RST_ONT  = 5'h00;

  // Time base: system clock, slow oscillator, PWM period, phase unit
  localparam int CLK_HZ        = 40000000;
  localparam int OSC_HZ        = 32000;
  localparam int PWM_PERIOD_US = 8000;
  localparam int PWM_SLOTS     = 32;
  localparam int UNIT_MS       = 64;
  localparam int OSC_DIV       = CLK_HZ / OSC_HZ;
  localparam int SLOT_TICKS    = (PWM_PERIOD_US * OSC_HZ) / (PWM_SLOTS * 1000000);
  localparam int PER_PER_UNIT  = (UNIT_MS * 1000) / PWM_PERIOD_US;

  localparam int OSC_W = 11;
  localparam logic [OSC_W-1:0]  OSC_LAST  = OSC_W'(OSC_DIV - 1);
  localparam logic [2:0]        SLOT_LAST = 3'(SLOT_TICKS - 1);
  localparam logic [DUTY_W-1:0] PWM_LAST  = DUTY_W'(PWM_SLOTS - 1);
  localparam logic [2:0]        PER_LAST  = 3'(PER_PER_UNIT - 1);

  // Sequence phases
  typedef enum logic [2:0] {
    PH_ONE,
    PH_TWO,
    PH_THREE,
    PH_FOUR,
    PH_PAUSE
  } lbds_phase_e;

endpackage

// ===== verilog/lbds_top.sv
// LED blink and dimming sequencer: register file, time base and phase sequencer
`timescale 1ns/1ps

module lbds_top
  import lbds_pkg::*;
(
  // Clock and power-on reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [7:0]        regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  output logic      [7:0]        regRdData,
  // LED A drive
  output logic                   aLightSignal,
  output logic      [CUR_W-1:0]  aSinkCurrentCode,
  output logic                   aRampSel,
  // LED B drive settings
  output logic      [CUR_W-1:0]  bSinkCurrentCode,
  output logic                   bRampSel,
  output logic      [LEN_W-1:0]  bPhase1Len
);

  // Register file state
  logic [CUR_W-1:0]  aCur_ff,    nxt_aCur;
  logic              aRamp_ff,   nxt_aRamp;
  logic [LEN_W-1:0]  aPh1_ff,    nxt_aPh1;
  logic [LEN_W-1:0]  aPh2_ff,    nxt_aPh2;
  logic [LEN_W-1:0]  aPh3_ff,    nxt_aPh3;
  logic [LEN_W-1:0]  aPh4_ff,    nxt_aPh4;
  logic [LEN_W-1:0]  aPause_ff,  nxt_aPause;
  logic [DUTY_W-1:0] aDuty_ff,   nxt_aDuty;
  logic [ONT_W-1:0]  aOnTime_ff, nxt_aOnTime;
  logic [CUR_W-1:0]  bCur_ff,    nxt_bCur;
  logic              bRamp_ff,   nxt_bRamp;
  logic [LEN_W-1:0]  bPh1_ff,    nxt_bPh1;
  logic [7:0]        rdData_ff,  nxt_rdData;

  // Time base and sequencer state
  logic [OSC_W-1:0]  oscDiv_ff,  nxt_oscDiv;
  logic [2:0]        slotTick_ff, nxt_slotTick;
  logic [DUTY_W-1:0] pwmSlot_ff, nxt_pwmSlot;
  logic [2:0]        period_ff,  nxt_period;
  logic [LEN_W-1:0]  unitCnt_ff, nxt_unitCnt;
  lbds_phase_e       phase_ff,   nxt_phase;
  logic              light_ff,   nxt_light;

  // Helpers of the sequencer
  logic              oscTick;
  logic              slotEnd;
  logic              periodEnd;
  logic              unitEnd;
  logic              lastUnit;
  logic              advance;
  logic [LEN_W-1:0]  curLen;
  logic              litPhase;

  // Register writes; reserved bits are never stored
  // Ramp bits are only stored and driven out; no ramp shaping happens here
  always_comb begin
    nxt_aCur    = aCur_ff;
    nxt_aRamp   = aRamp_ff;
    nxt_aPh1    = aPh1_ff;
    nxt_aPh2    = aPh2_ff;
    nxt_aPh3    = aPh3_ff;
    nxt_aPh4    = aPh4_ff;
    nxt_aPause  = aPause_ff;
    nxt_aDuty   = aDuty_ff;
    nxt_aOnTime = aOnTime_ff;
    nxt_bCur    = bCur_ff;
    nxt_bRamp   = bRamp_ff;
    nxt_bPh1    = bPh1_ff;
    if (regWrEn) begin
      case (regAddr)
        ADDR_A_CURRENT: begin
          nxt_aCur  = regWrData[CUR_W-1:0];
          nxt_aRamp = regWrData[RAMP_BIT];
        end
        ADDR_A_PH1:     nxt_aPh1    = regWrData[LEN_W-1:0];
        ADDR_A_PH2:     nxt_aPh2    = regWrData[LEN_W-1:0];
        ADDR_A_PH3:     nxt_aPh3    = regWrData[LEN_W-1:0];
        ADDR_A_PH4:     nxt_aPh4    = regWrData[LEN_W-1:0];
        ADDR_A_PAUSE:   nxt_aPause  = regWrData[LEN_W-1:0];
        ADDR_A_DUTY:    nxt_aDuty   = regWrData[DUTY_W-1:0];
        ADDR_A_ONTIME:  nxt_aOnTime = regWrData[ONT_W-1:0];
        ADDR_B_CURRENT: begin
          nxt_bCur  = regWrData[CUR_W-1:0];
          nxt_bRamp = regWrData[RAMP_BIT];
        end
        ADDR_B_PH1:     nxt_bPh1    = regWrData[LEN_W-1:0];
        default: begin
          // Writes to other offsets are dropped
        end
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_comb begin
    nxt_rdData = 8'h00;
    if (regRdEn) begin
      // Upper bits are zero-extended, so reserved bits read as zero
      case (regAddr)
        ADDR_A_CURRENT: nxt_rdData = {2'h0, aRamp_ff, 1'b0, aCur_ff};
        ADDR_A_PH1:     nxt_rdData = {1'b0, aPh1_ff};
        ADDR_A_PH2:     nxt_rdData = {1'b0, aPh2_ff};
        ADDR_A_PH3:     nxt_rdData = {1'b0, aPh3_ff};
        ADDR_A_PH4:     nxt_rdData = {1'b0, aPh4_ff};
        ADDR_A_PAUSE:   nxt_rdData = {1'b0, aPause_ff};
        ADDR_A_DUTY:    nxt_rdData = {3'h0, aDuty_ff};
        ADDR_A_ONTIME:  nxt_rdData = {3'h0, aOnTime_ff};
        ADDR_B_CURRENT: nxt_rdData = {2'h0, bRamp_ff, 1'b0, bCur_ff};
        ADDR_B_PH1:     nxt_rdData = {1'b0, bPh1_ff};
        default:        nxt_rdData = 8'h00; // Unmapped offsets read zero
      endcase
    end
  end

  // Register file flops, cleared on power-on reset; the read data flop is in its own block
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aCur_ff    <= RST_CUR;
      aRamp_ff   <= RST_RAMP;
      aPh1_ff    <= RST_LEN;
      aPh2_ff    <= RST_LEN;
      aPh3_ff    <= RST_LEN;
      aPh4_ff    <= RST_LEN;
      aPause_ff  <= RST_LEN;
      aDuty_ff   <= RST_DUTY;
      aOnTime_ff <= RST_ONT;
      bCur_ff    <= RST_CUR;
      bRamp_ff   <= RST_RAMP;
      bPh1_ff    <= RST_LEN;
    end else begin
      aCur_ff    <= nxt_aCur;
      aRamp_ff   <= nxt_aRamp;
      aPh1_ff    <= nxt_aPh1;
      aPh2_ff    <= nxt_aPh2;
      aPh3_ff    <= nxt_aPh3;
      aPh4_ff    <= nxt_aPh4;
      aPause_ff  <= nxt_aPause;
      aDuty_ff   <= nxt_aDuty;
      aOnTime_ff <= nxt_aOnTime;
      bCur_ff    <= nxt_bCur;
      bRamp_ff   <= nxt_bRamp;
      bPh1_ff    <= nxt_bPh1;
    end
  end

  // Read data flop; clears itself one cycle after each read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= 8'h00;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  // Length and lighting of the phase now running
  // Lit phases are one and three; two, four and pause stay dark
  always_comb begin
    curLen   = RST_LEN;
    litPhase = 1'b0;
    unique case (phase_ff)
      PH_ONE: begin
        curLen   = aPh1_ff;
        litPhase = 1'b1;
      end
      PH_TWO:   curLen = aPh2_ff;
      PH_THREE: begin
        curLen   = aPh3_ff;
        litPhase = 1'b1;
      end
      PH_FOUR:  curLen = aPh4_ff;
      PH_PAUSE: curLen = aPause_ff;
      default: begin
        curLen   = RST_LEN;
        litPhase = 1'b0;
      end
    endcase
  end

  // Time base carry chain: tick, slot, PWM period, then a whole unit of eight periods
  assign oscTick   = (oscDiv_ff == OSC_LAST);
  assign slotEnd   = oscTick && (slotTick_ff == SLOT_LAST);
  assign periodEnd = slotEnd && (pwmSlot_ff == PWM_LAST);
  assign unitEnd   = periodEnd && (period_ff == PER_LAST);
  // At or past the last unit, so a length cut short by software still ends the phase
  assign lastUnit  = (unitCnt_ff >= curLen - LEN_W'(1));

  // Sequencer next state; a phase change restarts the time base so units stay whole
  always_comb begin
    nxt_oscDiv   = oscDiv_ff + OSC_W'(1);
    nxt_slotTick = slotTick_ff;
    nxt_pwmSlot  = pwmSlot_ff;
    nxt_period   = period_ff;
    nxt_unitCnt  = unitCnt_ff;
    nxt_phase    = phase_ff;
    advance      = 1'b0;
    if (curLen == RST_LEN) begin
      advance = 1'b1;
    end else if (unitEnd && lastUnit) begin
      advance = 1'b1;
    end
    // Counting chain; the unit counter only moves on a whole unit
    if (oscTick) begin
      nxt_oscDiv   = '0;
      nxt_slotTick = slotTick_ff + 3'h1;
      if (slotTick_ff == SLOT_LAST) begin
        nxt_pwmSlot = pwmSlot_ff + DUTY_W'(1);
        if (pwmSlot_ff == PWM_LAST) begin
          nxt_period = period_ff + 3'h1;
          if (period_ff == PER_LAST) begin
            nxt_unitCnt = unitCnt_ff + LEN_W'(1);
          end
        end
      end
    end
    // A phase change wins over the counting above and restarts the time base
    if (advance) begin
      nxt_oscDiv   = '0;
      nxt_slotTick = 3'h0;
      nxt_pwmSlot  = '0;
      nxt_period   = 3'h0;
      nxt_unitCnt  = '0;
      // Fixed order one, two, three, four, pause, then round again
      unique case (phase_ff)
        PH_ONE:   nxt_phase = PH_TWO;
        PH_TWO:   nxt_phase = PH_THREE;
        PH_THREE: nxt_phase = PH_FOUR;
        PH_FOUR:  nxt_phase = PH_PAUSE;
        PH_PAUSE: nxt_phase = PH_ONE;
        default:  nxt_phase = PH_ONE;
      endcase
    end
  end

  // Light: lit phases, within the lit duration, while the PWM slot is below duty plus one
  always_comb begin
    nxt_light = 1'b0;
    if (litPhase && !advance && (unitCnt_ff < LEN_W'(aOnTime_ff))) begin
      // Slot index up to duty covers duty plus one slots; all ones covers every slot
      nxt_light = (pwmSlot_ff <= aDuty_ff);
    end
  end

  // Sequencer flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oscDiv_ff   <= '0;
      slotTick_ff <= 3'h0;
      pwmSlot_ff  <= '0;
      period_ff   <= 3'h0;
      unitCnt_ff  <= '0;
      phase_ff    <= PH_ONE;
    end else begin
      oscDiv_ff   <= nxt_oscDiv;
      slotTick_ff <= nxt_slotTick;
      pwmSlot_ff  <= nxt_pwmSlot;
      period_ff   <= nxt_period;
      unitCnt_ff  <= nxt_unitCnt;
      phase_ff    <= nxt_phase;
    end
  end

  // Light flop; the pin lags the sequencer state by one clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      light_ff <= 1'b0;
    end else begin
      light_ff <= nxt_light;
    end
  end

  // Outputs straight from flops
  assign regRdData        = rdData_ff;
  assign aLightSignal     = light_ff;
  assign aSinkCurrentCode = aCur_ff;
  assign aRampSel         = aRamp_ff;
  assign bSinkCurrentCode = bCur_ff;
  assign bRampSel         = bRamp_ff;
  assign bPhase1Len       = bPh1_ff;

endmodule // lbds_top
